// ==== logic/autoneg_regs_pkg.sv ====
// Constants shared by the auto-negotiation ability and identifier register logic
package autoneg_regs_pkg;

	// ==========================================================
	// Register indices and byte addresses
	localparam int unsigned          REG_IDX_W           = 8;
	localparam logic [REG_IDX_W-1:0] IDX_BASIC_STATUS    = 8'h01;
	localparam logic [REG_IDX_W-1:0] IDX_ID_LOW          = 8'h03;
	localparam logic [REG_IDX_W-1:0] IDX_LOCAL_ADVERTISE = 8'h04;
	localparam logic [REG_IDX_W-1:0] IDX_PARTNER_ABILITY = 8'h05;
	localparam logic [7:0]           ADDR_BASIC_STATUS    = IDX_BASIC_STATUS << 2;
	localparam logic [7:0]           ADDR_ID_LOW          = IDX_ID_LOW << 2;
	localparam logic [7:0]           ADDR_LOCAL_ADVERTISE = IDX_LOCAL_ADVERTISE << 2;
	localparam logic [7:0]           ADDR_PARTNER_ABILITY = IDX_PARTNER_ABILITY << 2;

	// ==========================================================
	// Identifier word fields
	localparam int unsigned ID_ORG_LSB   = 10;
	localparam int unsigned ID_MODEL_LSB = 4;
	localparam int unsigned ID_REV_LSB   = 0;

	// ==========================================================
	// Advertisement word fields
	localparam int unsigned ADV_MORE_PAGES_BIT = 15;
	localparam int unsigned ADV_FAULT_BIT      = 13;
	localparam int unsigned ADV_SPARE_BIT      = 12;
	localparam int unsigned ADV_ASYM_BIT       = 11;
	localparam int unsigned ADV_SYM_BIT        = 10;
	localparam int unsigned ADV_FOURPAIR_BIT   = 9;
	localparam int unsigned ADV_SPEED_MSB      = 8;
	localparam int unsigned ADV_SPEED_LSB      = 5;
	localparam logic [15:0] ADV_RESET          = 16'h0001;
	localparam logic [15:0] ADV_WRITE_MASK     = 16'hbfff;
	localparam logic [3:0]  ADV_NO_STRAP_SPEED = 4'hf;

	// ==========================================================
	// Partner ability word fields
	localparam logic [15:0] PARTNER_RESET         = 16'h0000;
	localparam logic [15:0] PARTNER_RESERVED_MASK = 16'h1000;

	// ==========================================================
	// Basic status word fields
	localparam int unsigned STATUS_DONE_BIT = 5;

	// ==========================================================
	// Strap capture timing, in ref_clk cycles after reset release
	localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;

endpackage

// ==== logic/partner_page_if.sv ====
// Carrier between the register front end and the partner page capture
`timescale 1ns/1ps
interface partner_page_if;
	logic [15:0] page_word;
	logic        page_valid;
	logic [15:0] ability_word;

	modport source (
		output page_word,
		output page_valid,
		input  ability_word
	);

	modport sink (
		input  page_word,
		input  page_valid,
		output ability_word
	);
endinterface

// ==== logic/partner_ability_capture.sv ====
// Holding register for the base page received from the link partner
`timescale 1ns/1ps
module partner_ability_capture (
	// Clock and reset
	input  wire logic    ref_clk,
	input  wire logic    srst,
	input  wire logic    clk_en,
	// Page path
	partner_page_if.sink pg
);

	logic [15:0] ability_reg;
	logic [15:0] ability_next;

	// ==========================================================
	// Whole-word load on a valid page
	always_comb begin
		ability_next = ability_reg;
		if (pg.page_valid) begin
			ability_next = pg.page_word & ~autoneg_regs_pkg::PARTNER_RESERVED_MASK; // see R14
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ability_reg <= autoneg_regs_pkg::PARTNER_RESET; // see R16
		end else if (clk_en) begin
			ability_reg <= ability_next; // see R18
		end
	end

	assign pg.ability_word = ability_reg; // see R12

endmodule

// ==== logic/autoneg_ability_id_regs.sv ====
// Identifier, local advertisement and partner ability registers behind Avalon-MM
`timescale 1ns/1ps

// Functional notes
// R1: Identifier bits 15..10 return organization identifier bits 19 to 24 in order.
// R2: Identifier bits 9..4 return the six-bit model code, MSB at bit 9.
// R3: Identifier bits 3..0 return the revision code, MSB at bit 3.
// R4: Host restarts negotiation after advertisement writes made before completion.
// R5: Advertisement bit 15 is read-write, requests further software next pages.
// R6: Advertisement bit 13 is read-write remote fault advertisement, reset zero.
// R7: Advertisement bit 11 is read-write asymmetric pause, reset zero.
// R8: Advertisement bit 10 is read-write symmetric pause, reset zero.
// R9: Advertisement bit 9, four-pair 100M, is plain storage, reset zero.
// R10: Advertisement bits 8..5 speed abilities; reset from straps, else one.
// R11: Advertisement bits 4..0 read-write selector, reset to 00001.
// R12: Partner register shows abilities received; may change after negotiation.
// R13: Partner bit 15 more pages, bit 14 acknowledge, read-only.
// R14: Partner bits 13, 11, 10 fault and pause; bit 12 reads zero.
// R15: Partner bits 9..5 report the partner technology abilities.
// R16: Partner register at index five is read-only, resets to zero.
// R17: Status bit 5 reads one once negotiation completed, else zero.
// R18: Partner register loads whole word in one cycle on a valid page.
module autoneg_ability_id_regs #(
	// Identity values; arbitrary
	parameter logic [5:0] ORG_ID_LOW = 6'h15,
	parameter logic [5:0] MODEL_CODE = 6'h2a,
	parameter logic [3:0] REV_CODE   = 4'h1
) (
	// Clock, reset, enable
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic        clk_en,
	// Avalon-MM slave
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Negotiation engine side
	input  wire logic [15:0] partner_page_word,
	input  wire logic        partner_page_valid,
	input  wire logic        negotiation_done,
	output logic      [15:0] local_advert_word,
	output logic             advert_update,
	output logic             advert_update_early,
	output logic      [15:0] partner_ability_word,
	// Configuration strap pins
	input  wire logic        strap_enable,
	input  wire logic [3:0]  strap_speed_duplex
);

	// ==========================================================
	// Identifier word
	logic [15:0] id_low_word;

	// Identity codes are fixed at build time by the parameters
	always_comb begin
		id_low_word = 16'h0000;
		id_low_word[autoneg_regs_pkg::ID_ORG_LSB +: 6]   = ORG_ID_LOW; // see R1
		id_low_word[autoneg_regs_pkg::ID_MODEL_LSB +: 6] = MODEL_CODE; // see R2
		id_low_word[autoneg_regs_pkg::ID_REV_LSB +: 4]   = REV_CODE;   // see R3
	end

	// ==========================================================
	// Strap pin synchronisers
	// Straps are asynchronous pins: two flops before any use
	logic [4:0] strap_meta_reg;
	logic [4:0] strap_sync_reg;
	logic [4:0] strap_meta_next;
	logic [4:0] strap_sync_next;

	always_comb begin
		strap_meta_next = {strap_enable, strap_speed_duplex};
		strap_sync_next = strap_meta_reg;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			strap_meta_reg <= 5'h00;
			strap_sync_reg <= 5'h00;
		end else if (clk_en) begin
			strap_meta_reg <= strap_meta_next;
			strap_sync_reg <= strap_sync_next;
		end
	end

	// ==========================================================
	// Strap capture sequencer
	// Loading waits until the synchroniser holds sampled pins
	typedef enum logic [1:0] {
		STRAP_SETTLE,
		STRAP_LOAD,
		STRAP_IDLE
	} strap_state_t;

	strap_state_t strap_state_reg;
	strap_state_t strap_state_next;
	logic [1:0]   strap_cnt_reg;
	logic [1:0]   strap_cnt_next;
	logic         strap_load;

	always_comb begin
		strap_state_next = strap_state_reg;
		strap_cnt_next   = strap_cnt_reg;
		strap_load       = 1'b0;
		case (strap_state_reg)
			STRAP_SETTLE: begin
				strap_cnt_next = strap_cnt_reg + 2'h1;
				if (strap_cnt_reg == autoneg_regs_pkg::STRAP_SETTLE_CYCLES - 2'h1) begin
					strap_state_next = STRAP_LOAD;
				end
			end
			STRAP_LOAD: begin
				strap_load       = 1'b1;
				strap_state_next = STRAP_IDLE;
			end
			STRAP_IDLE: begin
				strap_state_next = STRAP_IDLE;
			end
			default: begin
				strap_state_next = STRAP_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			strap_state_reg <= STRAP_SETTLE;
			strap_cnt_reg   <= 2'h0;
		end else if (clk_en) begin
			strap_state_reg <= strap_state_next;
			strap_cnt_reg   <= strap_cnt_next;
		end
	end

	// ==========================================================
	// Partner page capture
	// Bit 12 is cleared inside the capture module
	partner_page_if pg ();

	assign pg.page_word  = partner_page_word;
	assign pg.page_valid = partner_page_valid;

	partner_ability_capture u_capture (
		.ref_clk (ref_clk),
		.srst    (srst),
		.clk_en  (clk_en),
		.pg      (pg)
	);

	// ==========================================================
	// Negotiation status copy
	// Same-clock input; one flop keeps the read path registered
	logic done_reg;
	logic done_next;

	always_comb begin
		done_next = negotiation_done;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			done_reg <= 1'b0;
		end else if (clk_en) begin
			done_reg <= done_next; // see R17
		end
	end

	// ==========================================================
	// Bus decode
	// Byte addresses: register index times four
	logic        hit_status;
	logic        hit_id;
	logic        hit_adv;
	logic        hit_partner;
	logic        bus_req;
	logic [15:0] lane_mask;

	assign hit_status  = (avs_address == autoneg_regs_pkg::ADDR_BASIC_STATUS);
	assign hit_id      = (avs_address == autoneg_regs_pkg::ADDR_ID_LOW);
	assign hit_adv     = (avs_address == autoneg_regs_pkg::ADDR_LOCAL_ADVERTISE);
	assign hit_partner = (avs_address == autoneg_regs_pkg::ADDR_PARTNER_ABILITY);
	assign bus_req     = avs_read || avs_write;

	// One mask byte per enabled lane; lanes 2 and 3 are ignored
	for (genvar lane = 0; lane < 2; lane++) begin : g_lane_mask
		assign lane_mask[lane*8 +: 8] = {8{avs_byteenable[lane]}};
	end

	// ==========================================================
	// Register read mux
	logic [15:0] adv_reg;
	logic [15:0] read_word;

	always_comb begin
		read_word = 16'h0000;
		if (hit_status) begin
			read_word[autoneg_regs_pkg::STATUS_DONE_BIT] = done_reg; // see R17
		end else if (hit_id) begin
			read_word = id_low_word; // see R1 // see R2 // see R3
		end else if (hit_adv) begin
			read_word = adv_reg;
		end else if (hit_partner) begin
			read_word = pg.ability_word; // see R13 // see R14 // see R15 // see R16
		end
	end

	// ==========================================================
	// Bus handshake: one wait cycle, then one answer cycle
	logic        req_seen;
	logic        req_done;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic        wait_reg;
	logic        wait_next;

	assign req_seen = bus_req && wait_reg;
	assign req_done = bus_req && !wait_reg;

	// A request still held after its answer is taken as a new one
	always_comb begin
		rdata_next = rdata_reg;
		wait_next  = 1'b1;
		if (req_seen) begin
			// Answer prepared here so readdata comes from a flop
			wait_next = 1'b0;
			if (avs_read) begin
				rdata_next = {16'h0000, read_word};
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rdata_reg <= 32'h0000_0000;
			wait_reg  <= 1'b1;
		end else if (clk_en) begin
			rdata_reg <= rdata_next;
			wait_reg  <= wait_next;
		end
	end

	// ==========================================================
	// Advertisement register and update pulses
	logic [15:0] adv_next;
	logic        upd_reg;
	logic        upd_next;
	logic        early_reg;
	logic        early_next;
	logic [15:0] wr_mask;

	always_comb begin
		adv_next   = adv_reg;
		upd_next   = 1'b0;
		early_next = 1'b0;
		wr_mask    = lane_mask & autoneg_regs_pkg::ADV_WRITE_MASK;
		// Speed abilities from straps, or all ones when strapping is off
		if (strap_load) begin
			if (strap_sync_reg[4]) begin
				adv_next[autoneg_regs_pkg::ADV_SPEED_MSB:autoneg_regs_pkg::ADV_SPEED_LSB] =
					strap_sync_reg[3:0]; // see R10
			end else begin
				adv_next[autoneg_regs_pkg::ADV_SPEED_MSB:autoneg_regs_pkg::ADV_SPEED_LSB] =
					autoneg_regs_pkg::ADV_NO_STRAP_SPEED; // see R10
			end
		end
		// Write lands on the completing cycle, after any strap load
		// Bit 14 is outside the write mask and stays zero
		if (req_done && avs_write && hit_adv) begin
			// see R5 // see R6 // see R7 // see R8 // see R9 // see R11
			adv_next   = (adv_next & ~wr_mask) | (avs_writedata[15:0] & wr_mask);
			upd_next   = 1'b1;
			early_next = !done_reg; // see R4
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			adv_reg   <= autoneg_regs_pkg::ADV_RESET; // see R6 // see R7 // see R8 // see R11
			upd_reg   <= 1'b0;
			early_reg <= 1'b0;
		end else if (clk_en) begin
			adv_reg   <= adv_next;
			upd_reg   <= upd_next;
			early_reg <= early_next;
		end
	end

	// ==========================================================
	// Outputs
	// Every output below is a flop
	assign avs_readdata         = rdata_reg;
	assign avs_waitrequest      = wait_reg;
	assign local_advert_word    = adv_reg;
	assign advert_update        = upd_reg;
	assign advert_update_early  = early_reg;
	assign partner_ability_word = pg.ability_word; // see R12

endmodule

// ==== testbench/autoneg_regs_checker.sv ====
// Port-level checks of the register block
`timescale 1ns/1ps
module autoneg_regs_checker #(
	parameter logic [5:0] ORG_ID_LOW = 6'h15,
	parameter logic [5:0] MODEL_CODE = 6'h2a,
	parameter logic [3:0] REV_CODE   = 4'h1
) (
	// Watched ports
	input wire logic        ref_clk,
	input wire logic        srst,
	input wire logic        clk_en,
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic [15:0] partner_page_word,
	input wire logic        partner_page_valid,
	input wire logic        negotiation_done,
	input wire logic [15:0] local_advert_word,
	input wire logic        advert_update,
	input wire logic [15:0] partner_ability_word
);
	localparam logic [7:0] ADV = autoneg_regs_pkg::ADDR_LOCAL_ADVERTISE;
	logic ans;
	assign ans = !avs_waitrequest && clk_en;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// ====
	// Bus answers
	a_wait_one_low: assert property (ans |=> avs_waitrequest)
		else $error("waitrequest low twice");
	a_req_answered: assert property ((avs_read || avs_write) && avs_waitrequest && clk_en
		|=> !avs_waitrequest) else $error("request not answered");
	a_id_word: assert property (ans && avs_read
		&& avs_address == autoneg_regs_pkg::ADDR_ID_LOW
		|-> avs_readdata == {16'h0000, ORG_ID_LOW, MODEL_CODE, REV_CODE})
		else $error("identifier word wrong");
	a_status_bit: assert property (ans && avs_read
		&& avs_address == autoneg_regs_pkg::ADDR_BASIC_STATUS
		&& negotiation_done == $past(negotiation_done, 3)
		|-> avs_readdata == {26'h0, negotiation_done, 5'h00}) else $error("status bit wrong");
	// ====
	// Advertisement
	a_adv_write: assert property (ans && avs_write && avs_address == ADV
		&& avs_byteenable == 4'hf |=> local_advert_word
		== ($past(avs_writedata[15:0]) & autoneg_regs_pkg::ADV_WRITE_MASK))
		else $error("advertisement write wrong");
	a_update_pulse: assert property (ans && avs_write && avs_address == ADV
		|=> advert_update ##1 !advert_update) else $error("update pulse wrong");
	// ====
	// Partner page
	a_page_load: assert property (partner_page_valid && clk_en
		|=> partner_ability_word == ($past(partner_page_word)
		& ~autoneg_regs_pkg::PARTNER_RESERVED_MASK)) else $error("page load wrong");
	a_page_hold: assert property (!partner_page_valid && clk_en
		|=> $stable(partner_ability_word)) else $error("partner word changed");
endmodule

bind autoneg_ability_id_regs autoneg_regs_checker #(.ORG_ID_LOW(ORG_ID_LOW),
	.MODEL_CODE(MODEL_CODE), .REV_CODE(REV_CODE)) chk_inst (.ref_clk(ref_clk), .srst(srst),
	.clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.partner_page_word(partner_page_word), .partner_page_valid(partner_page_valid),
	.negotiation_done(negotiation_done), .local_advert_word(local_advert_word),
	.advert_update(advert_update), .partner_ability_word(partner_ability_word));

// ==== testbench/lp_model.sv ====
// Link partner and negotiation engine stand-in
`timescale 1ns/1ps
module lp_model (
	// Clock
	input wire logic    ref_clk,
	// Engine side
	output logic [15:0] page_word,
	output logic        page_valid,
	output logic        done
);
	initial begin
		page_word = 16'h5a5a;
		page_valid = 1'b0;
		done = 1'b0;
	end
	// One-cycle page; word scrambled once released
	task automatic send_page(input logic [15:0] w);
		page_word <= w;
		page_valid <= 1'b1;
		@(posedge ref_clk);
		page_word <= ~w;
		page_valid <= 1'b0;
	endtask
	task automatic set_done(input logic d);
		done <= d;
	endtask
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the register block
`timescale 1ns/1ps
module tb_top;
	localparam logic [7:0] ADV = autoneg_regs_pkg::ADDR_LOCAL_ADVERTISE;
	localparam logic [7:0] LPA = autoneg_regs_pkg::ADDR_PARTNER_ABILITY;
	localparam logic [7:0] IDL = autoneg_regs_pkg::ADDR_ID_LOW;
	localparam logic [7:0] STS = autoneg_regs_pkg::ADDR_BASIC_STATUS;
	logic        ref_clk = 1'b0;
	logic        srst = 1'b1;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hf;
	logic [31:0] avs_readdata, rd;
	logic        avs_waitrequest, page_valid, done, upd, upd_early;
	logic [15:0] page_word, adv_word, ability_word;
	logic        clk_en = 1'b1;
	logic        strap_enable = 1'b0;
	logic [3:0]  strap_speed_duplex = 4'h0;
	logic [15:0] pages[3] = '{16'hffff, 16'h1000, 16'h8421};
	logic [15:0] seen[3] = '{16'hefff, 16'h0000, 16'h8421};
	int          n_errors = 0;
	int          total_checks = 0;
	int          n_upd = 0;
	int          n_early = 0;

	initial begin
		forever #25 ref_clk = ~ref_clk;
	end

	autoneg_ability_id_regs autoneg_ability_id_regs_inst (.ref_clk(ref_clk), .srst(srst),
		.clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .partner_page_word(page_word),
		.partner_page_valid(page_valid), .negotiation_done(done),
		.local_advert_word(adv_word), .advert_update(upd), .advert_update_early(upd_early),
		.partner_ability_word(ability_word), .strap_enable(strap_enable),
		.strap_speed_duplex(strap_speed_duplex));
	lp_model lp_model_inst (.ref_clk(ref_clk), .page_word(page_word),
		.page_valid(page_valid), .done(done));

	always @(posedge ref_clk) begin
		if (upd === 1'b1) n_upd++;
		if (upd_early === 1'b1) n_early++;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		@(posedge ref_clk);
		check(rd, exp);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] be);
		avs_address <= a;
		avs_writedata <= {16'h0000, d};
		avs_byteenable <= be;
		avs_write <= 1'b1;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic print_verdict;
		if (n_errors == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#200000;
		n_errors++;
		print_verdict();
	end

	initial begin
		repeat (20) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rd_chk(ADV, 32'h01e1);
		rd_chk(LPA, 32'h0);
		rd_chk(IDL, 32'h56a1);
		rd_chk(STS, 32'h0);
		rd_chk(8'h40, 32'h0);
		wr(ADV, 16'hffff, 4'hf);
		rd_chk(ADV, 32'hbfff);
		wr(ADV, 16'h0000, 4'h1);
		rd_chk(ADV, 32'hbf00);
		wr(ADV, 16'h2400, 4'h2);
		check({16'h0, adv_word}, 32'h2400);
		lp_model_inst.set_done(1'b1);
		repeat (3) @(posedge ref_clk);
		rd_chk(STS, 32'h20);
		wr(ADV, 16'h0001, 4'hf);
		@(posedge ref_clk);
		check(32'(n_upd), 32'd4);
		check(32'(n_early), 32'd3);
		wr(LPA, 16'h5555, 4'hf);
		rd_chk(LPA, 32'h0);
		wr(IDL, 16'h0000, 4'hf);
		rd_chk(IDL, 32'h56a1);
		for (int i = 0; i < 3; i++) begin
			lp_model_inst.send_page(pages[i]);
			@(posedge ref_clk);
			check({16'h0, ability_word}, {16'h0, seen[i]});
			rd_chk(LPA, {16'h0, seen[i]});
		end
		clk_en <= 1'b0;
		lp_model_inst.send_page(16'h0021);
		@(posedge ref_clk);
		check({16'h0, ability_word}, 32'h8421);
		clk_en <= 1'b1;
		rd_chk(LPA, 32'h8421);
		strap_enable <= 1'b1;
		strap_speed_duplex <= 4'ha;
		srst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rd_chk(ADV, 32'h0141);
		rd_chk(LPA, 32'h0);
		print_verdict();
	end
endmodule
